// [verilog/relay_ctl_pkg.sv]
// Package for the relay selector and contact input logic.
// Assumes a single 50 MHz system clock; imported by relay_ctl and the bench, not by contact_filter.
package relay_ctl_pkg;
   // Register byte addresses (word index = byte address / 4)
   localparam logic [7:0] REG_RELAY_ONE_SEL   = 8'h00;
   localparam logic [7:0] REG_RELAY_TWO_SEL   = 8'h04;
   localparam logic [7:0] REG_RELAY_THREE_SEL = 8'h08;
   localparam logic [7:0] REG_RELAY_FOUR_SEL  = 8'h0c;
   localparam logic [7:0] REG_CONTACT_ONE_SEL = 8'h10;
   localparam logic [7:0] REG_CONTACT_TWO_SEL = 8'h14;
   localparam logic [7:0] REG_BUS_RELAY_CMD   = 8'h18;
   localparam logic [7:0] REG_STATUS          = 8'h1c;
   localparam logic [7:0] REG_DISPLAY         = 8'h20;
   localparam logic [7:0] REG_PRELUBE_TIME    = 8'h24;
   // Reset values and limits
   localparam logic [2:0] RELAY_SEL_RESET   = 3'h0;
   localparam logic [2:0] RELAY_ONE_SEL_MAX = 3'h7;
   localparam logic [2:0] RELAY_SEL_MAX     = 3'h6;
   localparam logic [1:0] CONTACT_SEL_RESET = 2'h1;
   localparam logic [15:0] PRELUBE_RESET    = 16'h0005;
   // Timing
   localparam int CLK_HZ          = 50_000_000;
   localparam int DEBOUNCE_MS     = 10;
   localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
   // Display characters
   localparam logic [7:0] CHAR_ON    = 8'hdb;
   localparam logic [7:0] CHAR_OFF   = 8'h5f;
   localparam logic [7:0] CHAR_LABEL = 8'h41;
   localparam logic [7:0] CHAR_DIGIT = 8'h30;
   localparam logic [7:0] CHAR_SPACE = 8'h20;

   // Relay function codes
   typedef enum logic [2:0] {
      FN_SYS_FAULT  = 3'b000,
      FN_LAG_PUMP   = 3'b001,
      FN_BUS_CTL    = 3'b010,
      FN_PUMP_FAULT = 3'b011,
      FN_OUT_ACTIVE = 3'b100,
      FN_DAMPER     = 3'b101,
      FN_PRELUBE    = 3'b110,
      FN_JOCKEY     = 3'b111
   } relay_fn_type;

   // Contact input function codes
   typedef enum logic [1:0] {
      CI_CLOSED_RUN = 2'b00,
      CI_OPEN_RUN   = 2'b01,
      CI_ALWAYS_RUN = 2'b10,
      CI_LATCH      = 2'b11
   } contact_fn_type;
endpackage : relay_ctl_pkg

// [verilog/contact_filter.sv]
// Synchroniser and debouncer for one dry contact input.
// Assumes an asynchronous pin level; output is a clean level on clk_in.
`timescale 1ns/100ps
module contact_filter #(
   parameter int STABLE_CYCLES = 500000
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // Raw pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0]  sync_q;
   logic [19:0] cnt_q;

   // Three stage sync; first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) sync_q <= 3'h0;
      else sync_q <= {sync_q[1:0], pin_in};
   end

   // Accept a change only after it held steady the whole window
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_q     <= 20'h0;
         level_out <= 1'b0;
      end else if (sync_q[1] != sync_q[2] || sync_q[2] == level_out) begin
         cnt_q <= 20'h0;
      end else if (cnt_q >= 20'(STABLE_CYCLES - 1)) begin
         cnt_q     <= 20'h0;
         level_out <= sync_q[2];
      end else begin
         cnt_q <= cnt_q + 20'h1;
      end
   end
endmodule : contact_filter

// [verilog/relay_ctl.sv]
// Relay selector and contact input logic of a motor drive controller.
// Assumes a drive core supplying status levels and a keypad confirm pulse.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module relay_ctl
   import relay_ctl_pkg::*;
#(
   parameter int DEBOUNCE = relay_ctl_pkg::DEBOUNCE_CYCLES,
   parameter int TICK     = relay_ctl_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // Drive status
   input  wire logic        drive_fault_in,
   input  wire logic        pump_fault_in,
   input  wire logic        lag_pump_in,
   input  wire logic        freq_nonzero_in,
   input  wire logic        at_min_freq_in,
   input  wire logic        auto_mode_in,
   input  wire logic        manual_mode_in,
   input  wire logic        running_in,
   input  wire logic        run_request_in,
   input  wire logic        confirm_key_in,
   // Contact pins
   input  wire logic        contact_input_one,
   input  wire logic        contact_input_two,
   input  wire logic        contact_input_three,
   input  wire logic        contact_input_four,
   // Relay contacts
   output logic             relay_one_open_contact,
   output logic             relay_one_closed_contact,
   output logic             relay_two_open_contact,
   output logic             relay_two_closed_contact,
   output logic             relay_three_open_contact,
   output logic             relay_three_common,
   output logic             relay_four_open_contact,
   output logic             relay_four_common,
   // Run control to drive core
   output logic             run_cmd_out,
   output logic             contact_fault_out,
   output logic             prelube_hold_out,
   // Display line, fifteen characters
   output logic             display_valid_out,
   output logic     [119:0] display_out
);
   import relay_ctl_pkg::*;

   logic [2:0]  relay_sel_q [4];
   logic [1:0]  contact_one_function_select_q;
   logic [1:0]  contact_two_sel_q;
   logic [3:0]  bus_cmd_q;
   logic [15:0] prelube_time_q;
   logic [3:0]  contact_lvl;
   logic [1:0]  latch_q;
   logic [3:0]  relay_d;
   logic [3:0]  relay_q;
   logic        prelube_on_q;
   logic [15:0] prelube_cnt_q;
   logic        prelube_wait_q;
   logic [31:0] tick_cnt_q;
   logic        tick;
   logic        run_d;
   logic        run_prev_q;
   logic [119:0] disp_d;

   // Replace a relay selector write above the legal range of that relay with the reset value
   function automatic logic [2:0] clamp_sel(input logic [2:0] v, input logic [2:0] mx);
      clamp_sel = (v > mx) ? RELAY_SEL_RESET : v;
   endfunction : clamp_sel

   // Run level from one contact input and its selector
   function automatic logic contact_run(input logic [1:0] sel, input logic lvl,
                                        input logic latched);
      case (contact_fn_type'(sel))
         CI_CLOSED_RUN: contact_run = lvl;
         CI_OPEN_RUN:   contact_run = !lvl;
         CI_ALWAYS_RUN: contact_run = 1'b1;
         CI_LATCH:      contact_run = !latched;
         default:       contact_run = 1'b0;
      endcase
   endfunction : contact_run

   // Debounced contact inputs
   contact_filter #(.STABLE_CYCLES(DEBOUNCE)) u_f1 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .pin_in(contact_input_one), .level_out(contact_lvl[0]));
   contact_filter #(.STABLE_CYCLES(DEBOUNCE)) u_f2 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .pin_in(contact_input_two), .level_out(contact_lvl[1]));
   contact_filter #(.STABLE_CYCLES(DEBOUNCE)) u_f3 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .pin_in(contact_input_three), .level_out(contact_lvl[2]));
   contact_filter #(.STABLE_CYCLES(DEBOUNCE)) u_f4 (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .pin_in(contact_input_four), .level_out(contact_lvl[3]));

   // Register writes; illegal selector values fall back to default
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 4; i++) relay_sel_q[i] <= RELAY_SEL_RESET;
         contact_one_function_select_q <= CONTACT_SEL_RESET;
         contact_two_sel_q             <= CONTACT_SEL_RESET;
         bus_cmd_q                     <= 4'h0;
         prelube_time_q                <= PRELUBE_RESET;
      end else if (wr_in) begin
         case (addr_in)
            REG_RELAY_ONE_SEL:
               relay_sel_q[0] <= clamp_sel(wdata_in[2:0], RELAY_ONE_SEL_MAX);
            REG_RELAY_TWO_SEL:
               relay_sel_q[1] <= clamp_sel(wdata_in[2:0], RELAY_SEL_MAX);
            REG_RELAY_THREE_SEL:
               relay_sel_q[2] <= clamp_sel(wdata_in[2:0], RELAY_SEL_MAX);
            REG_RELAY_FOUR_SEL:
               relay_sel_q[3] <= clamp_sel(wdata_in[2:0], RELAY_SEL_MAX);
            REG_CONTACT_ONE_SEL: contact_one_function_select_q <= wdata_in[1:0];
            REG_CONTACT_TWO_SEL: contact_two_sel_q             <= wdata_in[1:0];
            REG_BUS_RELAY_CMD:   bus_cmd_q      <= wdata_in[3:0];
            REG_PRELUBE_TIME:    prelube_time_q <= wdata_in[15:0];
            default: ;
         endcase
      end
   end

   // Register reads, data one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 32'h0;
      end else if (rd_in) begin
         case (addr_in)
            REG_RELAY_ONE_SEL:   rdata_out <= {29'h0, relay_sel_q[0]};
            REG_RELAY_TWO_SEL:   rdata_out <= {29'h0, relay_sel_q[1]};
            REG_RELAY_THREE_SEL: rdata_out <= {29'h0, relay_sel_q[2]};
            REG_RELAY_FOUR_SEL:  rdata_out <= {29'h0, relay_sel_q[3]};
            REG_CONTACT_ONE_SEL: rdata_out <= {30'h0, contact_one_function_select_q};
            REG_CONTACT_TWO_SEL: rdata_out <= {30'h0, contact_two_sel_q};
            REG_BUS_RELAY_CMD:   rdata_out <= {28'h0, bus_cmd_q};
            REG_STATUS: rdata_out <= {20'h0, prelube_on_q, run_cmd_out, latch_q,
                                      relay_q, contact_lvl};
            REG_PRELUBE_TIME:    rdata_out <= {16'h0, prelube_time_q};
            default:             rdata_out <= 32'h0;
         endcase
      end else begin
         rdata_out <= 32'h0;
      end
   end

   // 100 ms tick for the pre-lube countdown
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) tick_cnt_q <= 32'h0;
      else if (tick) tick_cnt_q <= 32'h0;
      else tick_cnt_q <= tick_cnt_q + 32'h1;
   end
   assign tick = (tick_cnt_q >= 32'(TICK - 1));

   // Latched contact faults; set wins over the confirm key
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         latch_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0 ? contact_one_function_select_q : contact_two_sel_q) == CI_LATCH
                && !contact_lvl[i])
               latch_q[i] <= 1'b1;
            else if (confirm_key_in)
               latch_q[i] <= 1'b0;
         end
      end
   end

   // Run decision from both programmed inputs
   always_comb begin
      run_d = contact_run(contact_one_function_select_q, contact_lvl[0], latch_q[0])
            & contact_run(contact_two_sel_q, contact_lvl[1], latch_q[1]);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         run_cmd_out       <= 1'b0;
         contact_fault_out <= 1'b0;
         run_prev_q        <= 1'b0;
      end else begin
         run_cmd_out       <= run_d & ~prelube_wait_q;
         contact_fault_out <= |latch_q;
         run_prev_q        <= run_request_in;
      end
   end

   // Pre-lube: energize on a new run, count, then release at min frequency
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         prelube_on_q   <= 1'b0;
         prelube_wait_q <= 1'b0;
         prelube_cnt_q  <= 16'h0;
      end else if (!run_request_in) begin
         prelube_on_q   <= 1'b0;
         prelube_wait_q <= 1'b0;
      end else if (run_request_in && !run_prev_q && (auto_mode_in || manual_mode_in)) begin
         prelube_on_q   <= 1'b1;
         prelube_wait_q <= 1'b1;
         prelube_cnt_q  <= prelube_time_q;
      end else if (prelube_wait_q) begin
         if (prelube_cnt_q == 16'h0) prelube_wait_q <= 1'b0;
         else if (tick) prelube_cnt_q <= prelube_cnt_q - 16'h1;
      end else if (at_min_freq_in) begin
         prelube_on_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) prelube_hold_out <= 1'b0;
      else prelube_hold_out <= prelube_wait_q;
   end

   // Relay function selection
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         case (relay_fn_type'(relay_sel_q[i]))
            FN_SYS_FAULT:  relay_d[i] = drive_fault_in;
            FN_LAG_PUMP:   relay_d[i] = lag_pump_in;
            FN_BUS_CTL:    relay_d[i] = bus_cmd_q[i];
            FN_PUMP_FAULT: relay_d[i] = pump_fault_in;
            FN_OUT_ACTIVE: relay_d[i] = freq_nonzero_in;
            FN_DAMPER:     relay_d[i] = contact_lvl[0] & auto_mode_in & running_in;
            FN_PRELUBE:    relay_d[i] = prelube_on_q;
            FN_JOCKEY:     relay_d[i] = (i == 0) & freq_nonzero_in;
            default:       relay_d[i] = 1'b0;
         endcase
      end
   end

   // Relay drivers; one and two have a closed contact as well
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         relay_q                  <= 4'h0;
         relay_one_open_contact   <= 1'b0;
         relay_one_closed_contact <= 1'b1;
         relay_two_open_contact   <= 1'b0;
         relay_two_closed_contact <= 1'b1;
         relay_three_open_contact <= 1'b0;
         relay_three_common       <= 1'b0;
         relay_four_open_contact  <= 1'b0;
         relay_four_common        <= 1'b0;
      end else begin
         relay_q                  <= relay_d;
         relay_one_open_contact   <= relay_d[0];
         relay_one_closed_contact <= ~relay_d[0];
         relay_two_open_contact   <= relay_d[1];
         relay_two_closed_contact <= ~relay_d[1];
         relay_three_open_contact <= relay_d[2];
         relay_three_common       <= relay_d[2];
         relay_four_open_contact  <= relay_d[3];
         relay_four_common        <= relay_d[3];
      end
   end

   // Status line "A1s A2s A3s A4s", 15 chars; spaces preset so the gaps between groups are blank
   always_comb begin
      disp_d = {15{CHAR_SPACE}};
      for (int i = 0; i < 4; i++) begin
         disp_d[119 - 32*i -: 8] = CHAR_LABEL;
         disp_d[111 - 32*i -: 8] = CHAR_DIGIT + 8'(i + 1);
         disp_d[103 - 32*i -: 8] = contact_lvl[i] ? CHAR_ON : CHAR_OFF;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         display_valid_out <= 1'b0;
         display_out       <= '0;
      end else begin
         display_valid_out <= auto_mode_in & ~running_in;
         display_out       <= disp_d;
      end
   end

   // Checks
   AST_LATCH_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (contact_one_function_select_q == CI_LATCH && !contact_lvl[0])
      |=> latch_q[0] ##1 (contact_fault_out && !run_cmd_out))
      else $error("latched input did not stop the motor");
   AST_LATCH_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (latch_q[0] && !confirm_key_in) |=> latch_q[0])
      else $error("latched fault cleared without confirm");
   AST_FAULT_RELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[0] == FN_SYS_FAULT) |=> relay_one_open_contact == $past(drive_fault_in))
      else $error("fault relay does not follow fault");
   AST_ACTIVE_RELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[1] == FN_OUT_ACTIVE) |=> relay_two_open_contact == $past(freq_nonzero_in))
      else $error("output active relay wrong");
   AST_JOCKEY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[0] == FN_JOCKEY && !freq_nonzero_in) |=> !relay_one_open_contact)
      else $error("jockey relay closed at zero frequency");
   AST_SEL_RANGE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      relay_sel_q[1] != FN_JOCKEY && relay_sel_q[2] != FN_JOCKEY && relay_sel_q[3] != FN_JOCKEY)
      else $error("function 7 on a relay other than one");
   AST_CONTACT_PAIR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      relay_one_open_contact != relay_one_closed_contact)
      else $error("relay one contacts not complementary");
   AST_ALWAYS_RUN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (contact_one_function_select_q == CI_ALWAYS_RUN && contact_two_sel_q == CI_ALWAYS_RUN
       && !prelube_wait_q) |=> run_cmd_out)
      else $error("always run selectors did not run");
   AST_DISPLAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> display_out[103:96] == ($past(contact_lvl[0]) ? CHAR_ON : CHAR_OFF))
      else $error("display symbol wrong");
   AST_LAG_RELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[0] == FN_LAG_PUMP) |=> relay_one_open_contact == $past(lag_pump_in))
      else $error("lag relay does not follow staging");
   AST_BUS_RELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[0] == FN_BUS_CTL) |=> relay_one_open_contact == $past(bus_cmd_q[0]))
      else $error("bus relay does not follow command");
   AST_PUMP_RELAY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (relay_sel_q[0] == FN_PUMP_FAULT) |=> relay_one_open_contact == $past(pump_fault_in))
      else $error("pump fault relay does not follow pump fault");
   AST_PRELUBE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      prelube_wait_q |=> (!run_cmd_out && prelube_hold_out))
      else $error("output allowed during pre-lube wait");
   AST_PAIR_TWO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      relay_two_open_contact != relay_two_closed_contact)
      else $error("relay two contacts not complementary");
endmodule : relay_ctl

// [verif/contact_model.sv]
// Model of the four dry contacts wired to the contact input pins.
// Assumes the bench sets wanted levels by non-blocking assignment at the clock edge.
`timescale 1ns/100ps
module contact_model (
   // Clock
   input  wire logic       clk_in,
   // Wanted switch levels and bounce enable
   input  wire logic [3:0] target_in,
   input  wire logic       bounce_in,
   // Switch pins, high = closed
   output logic      [3:0] pins_out
);
   logic [1:0] left_q = 2'h0;
   logic [3:0] last_q = 4'h0;
   logic [3:0] pin_q  = 4'h0;   // Switches start open

   // Chatter after a change; each bounce level lasts one cycle, far below the filter time
   always @(posedge clk_in) begin
      last_q <= target_in;
      if (bounce_in && target_in != last_q) begin
         left_q <= 2'h3;
         pin_q  <= ~pin_q;
      end else if (left_q != 2'h0) begin
         left_q <= left_q - 2'h1;
         pin_q  <= (left_q == 2'h1) ? target_in : ~pin_q;
      end else begin
         pin_q  <= target_in;
      end
   end

   assign pins_out = pin_q;
endmodule : contact_model

// [verif/tb_relay_ctl.sv]
// Self-checking bench for the relay selector and contact input logic.
// Assumes short debounce and tick parameters so each scenario stays brief.
`timescale 1ns/100ps
module tb_relay_ctl;
   import relay_ctl_pkg::*;
   localparam int DEB = 4;
   localparam int TCK = 3;
   logic        clk_in = 1'b0;
   logic        rst_n_in, wr_in, rd_in, bounce;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, rd_val;
   logic        drive_fault_in, pump_fault_in, lag_pump_in, freq_nonzero_in, at_min_freq_in;
   logic        auto_mode_in, manual_mode_in, running_in, run_request_in, confirm_key_in;
   logic [3:0]  target, pins;
   logic        r1o, r1c, r2o, r2c, r3o, r3c, r4o, r4c;
   logic        run_cmd_out, contact_fault_out, prelube_hold_out, display_valid_out;
   logic [119:0] display_out;
   int          mismatches = 0;
   int          num_checks = 0;

   relay_ctl #(.DEBOUNCE(DEB), .TICK(TCK)) relay_ctl_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .drive_fault_in(drive_fault_in),
      .pump_fault_in(pump_fault_in), .lag_pump_in(lag_pump_in),
      .freq_nonzero_in(freq_nonzero_in), .at_min_freq_in(at_min_freq_in),
      .auto_mode_in(auto_mode_in), .manual_mode_in(manual_mode_in), .running_in(running_in),
      .run_request_in(run_request_in), .confirm_key_in(confirm_key_in),
      .contact_input_one(pins[0]), .contact_input_two(pins[1]),
      .contact_input_three(pins[2]), .contact_input_four(pins[3]),
      .relay_one_open_contact(r1o), .relay_one_closed_contact(r1c),
      .relay_two_open_contact(r2o), .relay_two_closed_contact(r2c),
      .relay_three_open_contact(r3o), .relay_three_common(r3c),
      .relay_four_open_contact(r4o), .relay_four_common(r4c), .run_cmd_out(run_cmd_out),
      .contact_fault_out(contact_fault_out), .prelube_hold_out(prelube_hold_out),
      .display_valid_out(display_valid_out), .display_out(display_out));

   contact_model contact_model_inst (.clk_in(clk_in), .target_in(target), .bounce_in(bounce),
      .pins_out(pins));

   // 50 MHz clock
   always #10 clk_in = ~clk_in;

   // Compare, count, report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Leaves the bench just after an edge, so outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : settle

   // Register bus write: one cycle strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   // Register bus read: data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      {addr_in, rd_in} <= {a, 1'b1};
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask : rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      rd(a, rd_val);
      chk(rd_val, e);
   endtask : rd_chk

   task automatic set_contacts(input logic [3:0] v);
      @(posedge clk_in);
      target <= v;
      settle(16);
   endtask : set_contacts

   task automatic pulse_confirm;
      @(posedge clk_in);
      confirm_key_in <= 1'b1;
      @(posedge clk_in);
      confirm_key_in <= 1'b0;
      settle(4);
   endtask : pulse_confirm

   // Raise or drop the condition that a relay function watches
   task automatic cause(input logic [2:0] f, input logic v);
      if (f == 3'h2) wr(REG_BUS_RELAY_CMD, {31'h0, v});
      @(posedge clk_in);
      case (f)
         3'h0: drive_fault_in <= v;
         3'h1: lag_pump_in <= v;
         3'h3: pump_fault_in <= v;
         3'h5: {auto_mode_in, running_in, target} <= {v, v, 3'h0, v};
         3'h4, 3'h7: freq_nonzero_in <= v;
         default: ;
      endcase
   endtask : cause

   task automatic relay_fn(input logic [2:0] f);
      wr(REG_RELAY_ONE_SEL, {29'h0, f});
      cause(f, 1'b1);
      settle(16);
      chk({r1o, r1c}, 2'b10);
      cause(f, 1'b0);
      settle(16);
      chk({r1o, r1c}, 2'b01);
   endtask : relay_fn

   task automatic t_reset;
      rd_chk(REG_RELAY_ONE_SEL, 32'h0);
      rd_chk(REG_RELAY_FOUR_SEL, 32'h0);
      rd_chk(REG_CONTACT_ONE_SEL, 32'h1);
      rd_chk(REG_CONTACT_TWO_SEL, 32'h1);
      chk({r1o, r1c, r2o, r2c, r3o, r3c, r4o, r4c}, 8'b01010000);
      rd_chk(8'h30, 32'h0);
   endtask : t_reset

   task automatic t_clamp;
      wr(REG_RELAY_ONE_SEL, 32'h7);
      rd_chk(REG_RELAY_ONE_SEL, 32'h7);
      wr(REG_RELAY_TWO_SEL, 32'h7);
      rd_chk(REG_RELAY_TWO_SEL, 32'h0);
      wr(REG_RELAY_THREE_SEL, 32'h6);
      rd_chk(REG_RELAY_THREE_SEL, 32'h6);
      wr(REG_CONTACT_TWO_SEL, 32'h2);
      rd_chk(REG_CONTACT_TWO_SEL, 32'h2);
      wr(REG_CONTACT_TWO_SEL, 32'h1);
   endtask : t_clamp

   task automatic t_functions;
      relay_fn(3'h0);
      relay_fn(3'h1);
      relay_fn(3'h2);
      relay_fn(3'h3);
      relay_fn(3'h4);
      relay_fn(3'h5);
      relay_fn(3'h7);
      wr(REG_BUS_RELAY_CMD, 32'h1);
      settle(4);
      chk(r1o, 1'b0);
      wr(REG_RELAY_ONE_SEL, 32'h1);
      settle(4);
      chk(r1o, 1'b0);
      wr(REG_RELAY_FOUR_SEL, 32'h4);
      wr(REG_RELAY_TWO_SEL, 32'h4);
      cause(3'h4, 1'b1);
      settle(4);
      chk({r4o, r4c}, 2'b11);
      chk({r2o, r2c}, 2'b10);
      cause(3'h4, 1'b0);
   endtask : t_functions

   // Bouncing contacts must not reach the run logic until stable
   task automatic t_inputs;
      @(posedge clk_in);
      {bounce, target} <= {1'b1, 4'b1010};
      rd(REG_STATUS, rd_val);
      chk(rd_val[3:0], 4'h0);
      settle(16);
      rd(REG_STATUS, rd_val);
      chk(rd_val[3:0], 4'b1010);
      set_contacts(4'b0000);
      chk(run_cmd_out, 1'b1);
      set_contacts(4'b0001);
      chk(run_cmd_out, 1'b0);
      wr(REG_CONTACT_ONE_SEL, 32'h0);
      settle(4);
      chk(run_cmd_out, 1'b1);
      set_contacts(4'b0000);
      chk(run_cmd_out, 1'b0);
      wr(REG_CONTACT_TWO_SEL, 32'h2);
      wr(REG_CONTACT_ONE_SEL, 32'h2);
      settle(4);
      chk(run_cmd_out, 1'b1);
   endtask : t_inputs

   task automatic t_latch;
      set_contacts(4'b0001);
      wr(REG_CONTACT_ONE_SEL, 32'h3);
      settle(4);
      chk({contact_fault_out, run_cmd_out}, 2'b01);
      set_contacts(4'b0000);
      chk({contact_fault_out, run_cmd_out}, 2'b10);
      pulse_confirm();
      chk(contact_fault_out, 1'b1);
      set_contacts(4'b0001);
      chk({contact_fault_out, run_cmd_out}, 2'b10);
      pulse_confirm();
      chk({contact_fault_out, run_cmd_out}, 2'b01);
      wr(REG_CONTACT_ONE_SEL, 32'h0);
   endtask : t_latch

   task automatic t_display;
      int n_on, n_off, n_lab;
      {n_on, n_off, n_lab} = '0;
      @(posedge clk_in);
      {auto_mode_in, running_in, target} <= {2'b10, 4'b0101};
      settle(16);
      chk(display_valid_out, 1'b1);
      for (int i = 0; i < 15; i++) begin
         n_on  += int'(display_out[8*i +: 8] == CHAR_ON);
         n_off += int'(display_out[8*i +: 8] == CHAR_OFF);
         n_lab += int'(display_out[8*i +: 8] == CHAR_LABEL);
      end
      chk({n_on[3:0], n_off[3:0], n_lab[3:0]}, 12'h224);
      @(posedge clk_in);
      running_in <= 1'b1;
      settle(4);
      chk(display_valid_out, 1'b0);
   endtask : t_display

   // Pre-lube wait of two ticks, then release at minimum frequency
   task automatic t_prelube;
      int n;
      n = 0;
      wr(REG_RELAY_TWO_SEL, 32'h6);
      wr(REG_PRELUBE_TIME, 32'h2);
      set_contacts(4'b0001);
      @(posedge clk_in);
      {auto_mode_in, manual_mode_in, running_in, run_request_in} <= 4'b0101;
      settle(2);
      chk({r2o, r3o, r3c, prelube_hold_out, run_cmd_out}, 5'b11110);
      while (prelube_hold_out === 1'b1 && n < 100) begin
         settle(1);
         n++;
      end
      if (n == 100) begin
         mismatches++;
         report_and_stop();
      end
      chk(n >= 2 && n <= 2 * TCK + 4, 1'b1);
      settle(2);
      chk({r2o, run_cmd_out}, 2'b11);
      @(posedge clk_in);
      at_min_freq_in <= 1'b1;
      settle(4);
      chk(r2o, 1'b0);
   endtask : t_prelube

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      {rst_n_in, addr_in, wdata_in, wr_in, rd_in, target, bounce} = '0;
      {drive_fault_in, pump_fault_in, lag_pump_in, freq_nonzero_in, at_min_freq_in} = '0;
      {auto_mode_in, manual_mode_in, running_in, run_request_in, confirm_key_in} = '0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_clamp();
      t_functions();
      t_inputs();
      t_latch();
      t_display();
      t_prelube();
      report_and_stop();
   end

   // Hang guard
   initial begin
      #400000;
      mismatches++;
      report_and_stop();
   end
endmodule : tb_relay_ctl
